/* File: rtl/card_status_word_responder.v */
// Status word generator of a card command interpreter.
// Assumes a decoded header (class, instruction, P1, P2, Lc) per command
// plus file-system and toolkit condition inputs from the rest of the card.
// Notes on behaviour
// - Every answer ends with SW1 then SW2
// - Normal completion gives 90 00
// - Pending proactive command gives 91 plus length
// - Toolkit busy gives 93 00, stays usable
// - Warnings use 62 with 81/82/83
// - Binary update after retries gives 63 Cx count
// - Failed PIN gives 63 Cx remaining tries
// - Exhausted PIN gives 69 83 until unblocked
// - Binary read without file gives 69 86 if P1 bit 7 is clear
// - Bad P1 or P2 gives 6B 00
// - Record past end gives 6A 83
// - Binary read on record file gives 69 81
// - Select with wrong Lc gives 67 00
// - Unknown instruction gives 6D 00
// - Fetch with nothing pending gives 6F 00
// - Unknown class gives 6E 00
// - Unsupported channel class gives 6E 00
// - Secure messaging class gives 6E 00
// - Select of unknown file gives 6A 82
// - Update without access gives 69 82
`timescale 1ns/1ps
`include "sw_responder_regs.vh"

module card_status_word_responder (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Command header, valid for one cycle on i_cmd_valid
    input wire i_cmd_valid,
    input wire [7:0] i_cla,
    input wire [7:0] i_ins,
    input wire [7:0] i_p1,
    input wire [7:0] i_p2,
    input wire [7:0] i_lc,
    // Execution conditions from the file system and toolkit
    input wire i_pin_ok,
    input wire i_file_known,
    input wire i_ef_selected,
    input wire i_ef_is_record,
    input wire i_write_allowed,
    input wire i_rec_in_range,
    input wire i_offset_ok,
    input wire i_resp_pending,
    input wire [7:0] i_resp_len,
    input wire i_proactive,
    input wire i_toolkit_busy,
    input wire [1:0] i_warn_code,
    input wire [3:0] i_upd_retries,
    // Status word stream: SW1 then SW2
    output reg o_ready,
    output reg o_sw_valid,
    output reg [7:0] o_sw_byte,
    output reg o_sw_last,
    // Status word as a pair and PIN state
    output reg [7:0] o_sw1,
    output reg [7:0] o_sw2,
    output reg o_pin_blocked,
    output reg [1:0] o_pin_tries
);
    localparam ST_IDLE = 2'd0;
    localparam ST_LOOK = 2'd1;
    localparam ST_SW1 = 2'd2;
    localparam ST_SW2 = 2'd3;

    localparam OC_OK = 4'h0;
    localparam OC_BUSY = 4'h1;
    localparam OC_WARN = 4'h2;
    localparam OC_RETRY = 4'h3;
    localparam OC_BLOCKED = 4'h4;
    localparam OC_NO_EF = 4'h5;
    localparam OC_P1P2 = 4'h6;
    localparam OC_NO_REC = 4'h7;
    localparam OC_INCOMPAT = 4'h8;
    localparam OC_LEN = 4'h9;
    localparam OC_INS = 4'hA;
    localparam OC_TECH = 4'hB;
    localparam OC_CLA = 4'hC;
    localparam OC_NO_FILE = 4'hD;
    localparam OC_SEC = 4'hE;
    localparam OC_PROACTIVE = 4'hF;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [3:0] code_ff;
    reg [3:0] nxt_code;
    reg [3:0] nib_ff;
    reg [3:0] nxt_nib;
    reg [7:0] sw2_ovr_ff;
    reg [7:0] nxt_sw2_ovr;
    reg ovr_ff;
    reg nxt_ovr;
    reg [1:0] tries_ff;
    reg [1:0] nxt_tries;
    reg blocked_ff;
    reg nxt_blocked;
    reg [7:0] sw1_ff;
    reg [7:0] sw2_ff;
    wire [15:0] rom_word;
    wire [7:0] final_sw2;
    wire cla_ok;
    wire cla_sm;
    wire cla_chan;
    wire ins_known;
    wire [2:0] rec_mode;

    assign cla_ok = (i_cla[7:4] == `CLA_BASE_0) ||
                    (i_cla[7:4] == `CLA_BASE_8);
    assign cla_sm = i_cla[`CLA_SM_BIT];
    assign cla_chan = (i_cla[1:0] != 2'b00);
    assign rec_mode = i_p2[2:0];
    assign ins_known = (i_ins == `INS_SELECT) || (i_ins == `INS_STATUS) ||
        (i_ins == `INS_READ_BIN) || (i_ins == `INS_UPD_BIN) ||
        (i_ins == `INS_READ_REC) || (i_ins == `INS_UPD_REC) ||
        (i_ins == `INS_VERIFY) || (i_ins == `INS_UNBLOCK) ||
        (i_ins == `INS_GET_RESP);

    // Single outcome per command, earliest check wins
    always @* begin
        nxt_code = OC_OK;
        nxt_nib = 4'h0;
        nxt_ovr = 1'b0;
        nxt_sw2_ovr = 8'h00;
        nxt_tries = tries_ff;
        nxt_blocked = blocked_ff;
        if (!cla_ok || cla_sm || cla_chan) begin
            nxt_code = OC_CLA;
        end else if (!ins_known) begin
            nxt_code = OC_INS;
        end else if (i_toolkit_busy) begin
            nxt_code = OC_BUSY;
        end else begin
            case (i_ins)
                `INS_VERIFY: begin
                    if (blocked_ff) begin
                        nxt_code = OC_BLOCKED;
                    end else if (i_pin_ok) begin
                        nxt_tries = `PIN_TRIES;
                    end else begin
                        nxt_tries = tries_ff - 2'd1;
                        nxt_code = OC_RETRY;
                        nxt_nib = {2'b00, tries_ff - 2'd1};
                        if (tries_ff == 2'd1) begin
                            nxt_blocked = 1'b1;
                        end
                    end
                end
                `INS_UNBLOCK: begin
                    if (i_pin_ok) begin
                        nxt_blocked = 1'b0;
                        nxt_tries = `PIN_TRIES;
                    end else begin
                        nxt_code = OC_SEC;
                    end
                end
                `INS_SELECT: begin
                    if (i_lc != `SELECT_LC) begin
                        nxt_code = OC_LEN;
                    end else if (!i_file_known) begin
                        nxt_code = OC_NO_FILE;
                    end
                end
                `INS_READ_BIN: begin
                    if (!i_p1[7] && !i_ef_selected) begin
                        nxt_code = OC_NO_EF;
                    end else if (i_ef_is_record) begin
                        nxt_code = OC_INCOMPAT;
                    end else if (!i_offset_ok) begin
                        nxt_code = OC_P1P2;
                    end
                end
                `INS_UPD_BIN: begin
                    if (!i_ef_selected) begin
                        nxt_code = OC_NO_EF;
                    end else if (!i_write_allowed) begin
                        nxt_code = OC_SEC;
                    end else if (!i_offset_ok) begin
                        nxt_code = OC_P1P2;
                    end else if (i_upd_retries != 4'h0) begin
                        nxt_code = OC_RETRY;
                        nxt_nib = i_upd_retries;
                    end
                end
                `INS_READ_REC, `INS_UPD_REC: begin
                    if (rec_mode != `REC_MODE_NEXT &&
                        rec_mode != `REC_MODE_PREV &&
                        rec_mode != `REC_MODE_ABS) begin
                        nxt_code = OC_P1P2;
                    end else if (!i_rec_in_range) begin
                        nxt_code = OC_NO_REC;
                    end else if (i_ins == `INS_UPD_REC &&
                                 !i_write_allowed) begin
                        nxt_code = OC_SEC;
                    end
                end
                `INS_GET_RESP: begin
                    if (!i_resp_pending) begin
                        nxt_code = OC_TECH;
                    end
                end
                default: begin
                    nxt_code = OC_OK;
                end
            endcase
            if (nxt_code == OC_OK && i_warn_code != 2'b00) begin
                nxt_code = OC_WARN;
                nxt_ovr = 1'b1;
                case (i_warn_code)
                    2'b01: nxt_sw2_ovr = `SW2_WARN_CORRUPT;
                    2'b10: nxt_sw2_ovr = `SW2_WARN_EOF;
                    default: nxt_sw2_ovr = `SW2_WARN_INVALID;
                endcase
            end else if (nxt_code == OC_OK && i_proactive) begin
                nxt_code = OC_PROACTIVE;
                nxt_ovr = 1'b1;
                nxt_sw2_ovr = i_resp_len;
            end
        end
    end

    sw_outcome_rom u_rom (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_addr(code_ff),
        .i_nibble(nib_ff),
        .o_word(rom_word)
    );

    assign final_sw2 = ovr_ff ? sw2_ovr_ff : rom_word[7:0];

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    nxt_state = ST_LOOK;
                end
            end
            ST_LOOK: nxt_state = ST_SW1;
            ST_SW1: nxt_state = ST_SW2;
            ST_SW2: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @* begin
        o_ready = (state_ff == ST_IDLE);
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            code_ff <= OC_OK;
            nib_ff <= 4'h0;
            ovr_ff <= 1'b0;
            sw2_ovr_ff <= 8'h00;
            tries_ff <= `PIN_TRIES;
            blocked_ff <= 1'b0;
            sw1_ff <= 8'h00;
            sw2_ff <= 8'h00;
            o_sw_valid <= 1'b0;
            o_sw_byte <= 8'h00;
            o_sw_last <= 1'b0;
            o_sw1 <= 8'h00;
            o_sw2 <= 8'h00;
            o_pin_blocked <= 1'b0;
            o_pin_tries <= `PIN_TRIES;
        end else begin
            state_ff <= nxt_state;
            o_sw_valid <= 1'b0;
            o_sw_last <= 1'b0;
            if (state_ff == ST_IDLE && i_cmd_valid) begin
                code_ff <= nxt_code;
                nib_ff <= nxt_nib;
                ovr_ff <= nxt_ovr;
                sw2_ovr_ff <= nxt_sw2_ovr;
                tries_ff <= nxt_tries;
                blocked_ff <= nxt_blocked;
            end
            if (state_ff == ST_SW1) begin
                sw1_ff <= rom_word[15:8];
                sw2_ff <= final_sw2;
                o_sw_valid <= 1'b1;
                o_sw_byte <= rom_word[15:8];
            end
            if (state_ff == ST_SW2) begin
                o_sw_valid <= 1'b1;
                o_sw_byte <= sw2_ff;
                o_sw_last <= 1'b1;
                o_sw1 <= sw1_ff;
                o_sw2 <= sw2_ff;
            end
            o_pin_blocked <= blocked_ff;
            o_pin_tries <= tries_ff;
        end
    end
endmodule // card_status_word_responder

/* File: inc/sw_responder_regs.vh */
// Status word codes, class and instruction values, PIN retry limits.
// Included by the responder and its outcome memory; definitions only.
`ifndef SW_RESPONDER_REGS_VH
`define SW_RESPONDER_REGS_VH

`define SW1_OK 8'h90
`define SW1_PROACTIVE 8'h91
`define SW1_BUSY 8'h93
`define SW1_WARN 8'h62
`define SW1_RETRY 8'h63
`define SW1_WRONG_LEN 8'h67
`define SW1_CLA_FUNC 8'h68
`define SW1_NOT_ALLOWED 8'h69
`define SW1_WRONG_PARAM 8'h6A
`define SW1_BAD_P1P2 8'h6B
`define SW1_BAD_INS 8'h6D
`define SW1_BAD_CLA 8'h6E
`define SW1_TECH 8'h6F

`define SW2_NONE 8'h00
`define SW2_WARN_CORRUPT 8'h81
`define SW2_WARN_EOF 8'h82
`define SW2_WARN_INVALID 8'h83
`define SW2_RETRY_BASE 8'hC0
`define SW2_CHAN_UNSUP 8'h81
`define SW2_SM_UNSUP 8'h82
`define SW2_INCOMPAT 8'h81
`define SW2_SEC_STATUS 8'h82
`define SW2_PIN_BLOCKED 8'h83
`define SW2_NO_EF 8'h86
`define SW2_REC_NOT_FOUND 8'h83
`define SW2_FILE_NOT_FOUND 8'h82
`define SW2_LC_INCONS 8'h87

// Class byte layout
`define CLA_BASE_0 4'h0
`define CLA_BASE_8 4'h8
`define CLA_SM_BIT 2
`define CLA_CHAN_LSB 0

// Instruction codes
`define INS_SELECT 8'hA4
`define INS_STATUS 8'hF2
`define INS_READ_BIN 8'hB0
`define INS_UPD_BIN 8'hD6
`define INS_READ_REC 8'hB2
`define INS_UPD_REC 8'hDC
`define INS_VERIFY 8'h20
`define INS_UNBLOCK 8'h2C
`define INS_GET_RESP 8'hC0

// Data length that a file selection must carry
`define SELECT_LC 8'h02

// Record modes held in P2 low bits
`define REC_MODE_NEXT 3'h2
`define REC_MODE_PREV 3'h3
`define REC_MODE_ABS 3'h4

`define PIN_TRIES 2'h3

// Outcome memory geometry
`define OUT_DEPTH 16
`define OUT_AW 4

`endif

/* File: rtl/sw_outcome_rom.v */
// Registered lookup from outcome code to the SW1/SW2 pair.
// Assumes the shared status code header; one-cycle read latency.
`timescale 1ns/1ps
`include "sw_responder_regs.vh"

module sw_outcome_rom (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Lookup
    input wire [`OUT_AW-1:0] i_addr,
    input wire [3:0] i_nibble,
    output reg [15:0] o_word
);
    reg [15:0] base;

    always @* begin
        case (i_addr)
            4'h0: base = {`SW1_OK, `SW2_NONE};
            4'h1: base = {`SW1_BUSY, `SW2_NONE};
            4'h2: base = {`SW1_WARN, `SW2_NONE};
            4'h3: base = {`SW1_RETRY, `SW2_RETRY_BASE};
            4'h4: base = {`SW1_NOT_ALLOWED, `SW2_PIN_BLOCKED};
            4'h5: base = {`SW1_NOT_ALLOWED, `SW2_NO_EF};
            4'h6: base = {`SW1_BAD_P1P2, `SW2_NONE};
            4'h7: base = {`SW1_WRONG_PARAM, `SW2_REC_NOT_FOUND};
            4'h8: base = {`SW1_NOT_ALLOWED, `SW2_INCOMPAT};
            4'h9: base = {`SW1_WRONG_LEN, `SW2_NONE};
            4'hA: base = {`SW1_BAD_INS, `SW2_NONE};
            4'hB: base = {`SW1_TECH, `SW2_NONE};
            4'hC: base = {`SW1_BAD_CLA, `SW2_NONE};
            4'hD: base = {`SW1_WRONG_PARAM, `SW2_FILE_NOT_FOUND};
            4'hE: base = {`SW1_NOT_ALLOWED, `SW2_SEC_STATUS};
            default: base = {`SW1_PROACTIVE, `SW2_NONE};
        endcase
    end

    // Entry 3 carries a count in its low nibble; entries 2 and 15
    // take a full SW2 from the override path in the caller
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_word <= 16'h0000;
        end else if (i_addr == 4'h3) begin
            o_word <= {base[15:4], i_nibble};
        end else begin
            o_word <= base;
        end
    end
endmodule // sw_outcome_rom

/* File: bench/sw_responder_props.sv */
// Port assertions for the status word responder.
// Bound to the responder; one clock, async active-high reset.
`timescale 1ns/1ps

module sw_responder_props (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Command
    input wire i_cmd_valid,
    input wire [7:0] i_cla,
    input wire [7:0] i_ins,
    input wire i_pin_ok,
    input wire i_toolkit_busy,
    // Status
    input wire o_ready,
    input wire o_sw_valid,
    input wire [7:0] o_sw_byte,
    input wire o_sw_last,
    input wire [7:0] o_sw1,
    input wire [7:0] o_sw2,
    input wire o_pin_blocked,
    input wire [1:0] o_pin_tries
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    wire acc = i_cmd_valid && o_ready;
    wire good = acc && (i_cla == 8'h00 || i_cla == 8'h80);
    wire ins_ok = i_ins == 8'hA4 || i_ins == 8'hF2 || i_ins == 8'hB0 ||
        i_ins == 8'hD6 || i_ins == 8'hB2 || i_ins == 8'hDC ||
        i_ins == 8'h20 || i_ins == 8'h2C || i_ins == 8'hC0;
    wire pin = good && i_ins == 8'h20 && !i_toolkit_busy;

    AST_STREAM: assert property (
        acc |-> ##3 o_sw_valid && !o_sw_last ##1 o_sw_valid && o_sw_last
        ##1 !o_sw_valid) else $error("status bytes out of order");
    AST_READY: assert property (
        acc |=> !o_ready [*3] ##1 o_ready) else $error("ready timing");
    AST_PAIR: assert property (
        o_sw_last |-> $past(o_sw_valid) && o_sw2 == o_sw_byte
        && o_sw1 == $past(o_sw_byte)) else $error("pair mismatch");
    AST_HOLD: assert property (
        !o_sw_last |-> $stable(o_sw1) && $stable(o_sw2))
        else $error("pair changed");
    AST_BAD_CLA: assert property (
        acc && i_cla[7:4] != 4'h0 && i_cla[7:4] != 4'h8 |->
        ##4 o_sw1 == 8'h6E && o_sw2 == 8'h00) else $error("class");
    AST_CHAN: assert property (
        acc && i_cla[1:0] != 2'h0 |-> ##4 {o_sw1, o_sw2} == 16'h6E00)
        else $error("channel class");
    AST_SM: assert property (
        acc && i_cla[2] |-> ##4 {o_sw1, o_sw2} == 16'h6E00)
        else $error("secure class");
    AST_BAD_INS: assert property (
        good && !ins_ok |-> ##4 {o_sw1, o_sw2} == 16'h6D00)
        else $error("instruction");
    AST_BUSY: assert property (
        good && ins_ok && i_toolkit_busy |-> ##4 {o_sw1, o_sw2} == 16'h9300)
        else $error("busy");
    AST_PIN: assert property (
        pin && !i_pin_ok && !o_pin_blocked && o_pin_tries != 2'h0 |->
        ##4 o_sw1 == 8'h63 && o_sw2 == {6'h30, $past(o_pin_tries, 4) - 2'h1})
        else $error("pin tries");
    AST_BLOCKED: assert property (
        pin && o_pin_blocked |-> ##4 {o_sw1, o_sw2} == 16'h6983)
        else $error("pin blocked");
endmodule // sw_responder_props

bind card_status_word_responder sw_responder_props sw_responder_props_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cla(i_cla), .i_ins(i_ins), .i_pin_ok(i_pin_ok),
    .i_toolkit_busy(i_toolkit_busy), .o_ready(o_ready),
    .o_sw_valid(o_sw_valid), .o_sw_byte(o_sw_byte), .o_sw_last(o_sw_last),
    .o_sw1(o_sw1), .o_sw2(o_sw2), .o_pin_blocked(o_pin_blocked),
    .o_pin_tries(o_pin_tries));

/* File: bench/terminal_model.sv */
// Terminal model: presents one command header and gathers SW1, SW2.
// Assumes the responder takes a command on ready and streams two bytes.
`timescale 1ns/1ps

module terminal_model (
    // Clock
    input wire i_clk,
    // Responder side
    input wire i_ready,
    input wire i_sw_valid,
    input wire [7:0] i_sw_byte,
    input wire i_sw_last,
    // Header: class, instruction, P1, P2, length
    output reg o_cmd_valid,
    output reg [39:0] o_hdr
);
    initial begin
        o_cmd_valid = 1'b0;
        o_hdr = 40'h0;
    end

    task send(input [39:0] h, output [15:0] sw);
        integer n;
        reg done;
        sw = 16'hXXXX;
        done = 1'b0;
        n = 0;
        @(posedge i_clk);
        o_hdr <= h;
        o_cmd_valid <= 1'b1;
        @(posedge i_clk);
        while (!i_ready && n < 8) begin
            @(posedge i_clk);
            n = n + 1;
        end
        o_cmd_valid <= 1'b0;
        // Released header lines must not keep the old value
        o_hdr <= ~h;
        for (n = 0; n < 8 && !done; n = n + 1) begin
            @(posedge i_clk);
            if (i_sw_valid && !i_sw_last)
                sw[15:8] = i_sw_byte;
            if (i_sw_valid && i_sw_last) begin
                sw[7:0] = i_sw_byte;
                done = 1'b1;
            end
        end
    endtask
endmodule // terminal_model

/* File: bench/tb_card_status_word_responder.sv */
// Self-checking bench for the status word responder.
// Drives the condition inputs itself; the terminal model sends commands.
`timescale 1ns/1ps

module tb_card_status_word_responder;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg [9:0] cnd = 10'h0F7;
    reg [1:0] warn = 2'h0;
    reg [3:0] retr = 4'h0;
    reg [7:0] rlen = 8'h00;
    reg [15:0] got;
    wire cmd_valid, ready, sw_valid, sw_last, pin_blocked;
    wire [39:0] hdr;
    wire [7:0] sw_byte, sw1, sw2;
    wire [1:0] pin_tries;
    integer n_fail = 0;
    integer samples_checked = 0;

    always #4 i_clk = ~i_clk;

    terminal_model terminal_model_i (
        .i_clk(i_clk), .i_ready(ready), .i_sw_valid(sw_valid),
        .i_sw_byte(sw_byte), .i_sw_last(sw_last),
        .o_cmd_valid(cmd_valid), .o_hdr(hdr));

    // Condition bits: pin, file, ef, record, write, range, offset,
    // pending, proactive, busy
    card_status_word_responder card_status_word_responder_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
        .i_cla(hdr[39:32]), .i_ins(hdr[31:24]), .i_p1(hdr[23:16]),
        .i_p2(hdr[15:8]), .i_lc(hdr[7:0]), .i_pin_ok(cnd[0]),
        .i_file_known(cnd[1]), .i_ef_selected(cnd[2]),
        .i_ef_is_record(cnd[3]), .i_write_allowed(cnd[4]),
        .i_rec_in_range(cnd[5]), .i_offset_ok(cnd[6]),
        .i_resp_pending(cnd[7]), .i_resp_len(rlen), .i_proactive(cnd[8]),
        .i_toolkit_busy(cnd[9]), .i_warn_code(warn), .i_upd_retries(retr),
        .o_ready(ready), .o_sw_valid(sw_valid), .o_sw_byte(sw_byte),
        .o_sw_last(sw_last), .o_sw1(sw1), .o_sw2(sw2),
        .o_pin_blocked(pin_blocked), .o_pin_tries(pin_tries));

    task cmp(input [15:0] g, input [15:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // PIN state as {blocked, remaining tries}
    task cmp_pin(input [2:0] g, input [2:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Flip mask inverts chosen bits of the all-good condition set
    task chk(input [39:0] h, input [9:0] fl, input [15:0] e);
        @(posedge i_clk);
        cnd <= 10'h0F7 ^ fl;
        terminal_model_i.send(h, got);
        cmp(got, e);
        cmp({sw1, sw2}, e);
    endtask

    task s_pin;
        integer k;
        cmp_pin({pin_blocked, pin_tries}, 3'h3);
        for (k = 2; k >= 0; k = k - 1)
            chk(40'h0020000108, 10'h001, {12'h63C, 2'h0, k[1:0]});
        cmp_pin({pin_blocked, pin_tries}, 3'h4);
        chk(40'h0020000108, 10'h000, 16'h6983);
        chk(40'h002C000110, 10'h000, 16'h9000);
        cmp_pin({pin_blocked, pin_tries}, 3'h3);
    endtask

    // Reset in mid-run restores the full PIN tries and clears the pair
    task s_reset;
        chk(40'h0020000108, 10'h001, 16'h63C2);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        cmp_pin({pin_blocked, pin_tries}, 3'h3);
        cmp({sw1, sw2}, 16'h0000);
        chk(40'h0020000108, 10'h001, 16'h63C2);
        chk(40'h0020000108, 10'h000, 16'h9000);
    endtask

    task s_normal;
        chk(40'h00A4000402, 10'h000, 16'h9000);
        chk(40'h80F2000000, 10'h000, 16'h9000);
    endtask

    task s_toolkit;
        rlen <= 8'h1C;
        chk(40'h80F2000000, 10'h100, 16'h911C);
        chk(40'h80F2000000, 10'h200, 16'h9300);
        chk(40'h80F2000000, 10'h000, 16'h9000);
    endtask

    task s_warn;
        integer w;
        for (w = 1; w < 4; w = w + 1) begin
            warn <= w[1:0];
            chk(40'h00B0000010, 10'h000, {8'h62, 8'h80 + w[7:0]});
        end
        warn <= 2'h0;
        retr <= 4'h5;
        chk(40'h00D6000002, 10'h000, 16'h63C5);
        retr <= 4'h0;
    endtask

    task s_checks;
        chk(40'h00B2000401, 10'h008, 16'h9000);
        chk(40'h00DC000401, 10'h010, 16'h6982);
        chk(40'h002C000110, 10'h001, 16'h6982);
        chk(40'h00D6000002, 10'h004, 16'h6986);
        chk(40'h00B0000001, 10'h004, 16'h6986);
        chk(40'h00B0000001, 10'h040, 16'h6B00);
        chk(40'h00B2010101, 10'h008, 16'h6B00);
        chk(40'h00B2000301, 10'h028, 16'h6A83);
        chk(40'h00B2000201, 10'h028, 16'h6A83);
        chk(40'h00B0000001, 10'h008, 16'h6981);
        chk(40'h00A4000401, 10'h000, 16'h6700);
        chk(40'h006F000000, 10'h000, 16'h6D00);
        chk(40'h00C0000000, 10'h080, 16'h6F00);
        chk(40'h40C0000000, 10'h000, 16'h6E00);
        chk(40'h81F2000000, 10'h000, 16'h6E00);
        chk(40'h84F2000002, 10'h000, 16'h6E00);
        chk(40'h00A4000402, 10'h002, 16'h6A82);
        chk(40'h00D6000002, 10'h010, 16'h6982);
        chk(40'h406F000000, 10'h208, 16'h6E00);
        chk(40'h006F000000, 10'h240, 16'h6D00);
    endtask

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        s_pin;
        s_reset;
        s_normal;
        s_toolkit;
        s_warn;
        s_checks;
        report_and_stop;
    end

    // About 37 commands of some 7 cycles each; ample margin
    initial begin
        #20000;
        n_fail = n_fail + 1;
        report_and_stop;
    end
endmodule // tb_card_status_word_responder
